// *** rtl/pin_func_sel_pkg.sv ***
// constants for the port 3 upper / port 4 lower pin function select block
// assumes a single 125 MHz clock and one AHB-Lite master
// ----------------------------------------
// How it works
// RQ1: pin 37 select sits in bits 7:6 of register 0x52a7, reset 0x0.
// RQ2: pin 36 select sits in bits 5:4, reset 0x0, code 0x3 reserved.
// RQ3: pin 35 select in bits 3:2 picks port or debug clock, 0x3/0x2 reserved.
// RQ4: pin 34 code 0x2 spi1 slave select, 0x1 remote out, 0x0 port.
// RQ5: pin 43 in 0x52a8 bits 7:6: 0x2 remote in, 0x1 i2c1 data, 0x0 port.
// RQ6: pin 42 bits 5:4: 0x2 timer1 out/capture, 0x1 spi0 clock, 0x0 port.
// RQ7: pin 41 select in bits 3:2 of second register, reset 0x0, 0x3 reserved.
// RQ8: selected peripheral owns pin paths; port code gives control back to port.
// ----------------------------------------
package pin_func_sel_pkg;

  localparam int          NPINS = 7;

  // pin order on every vector: 34, 35, 36, 37, 41, 42, 43
  localparam int          PIN34 = 0;
  localparam int          PIN35 = 1;
  localparam int          PIN36 = 2;
  localparam int          PIN37 = 3;
  localparam int          PIN41 = 4;
  localparam int          PIN42 = 5;
  localparam int          PIN43 = 6;

  // printed offsets are register indices; byte address is four times that
  localparam logic [15:0] P3U_IDX  = 16'h52A7;
  localparam logic [15:0] P4L_IDX  = 16'h52A8;
  localparam logic [31:0] P3U_ADDR = {14'h0000, P3U_IDX, 2'b00};
  localparam logic [31:0] P4L_ADDR = {14'h0000, P4L_IDX, 2'b00};

  localparam logic [7:0]  SEL_RESET = 8'h00;

  localparam logic [1:0]  CODE0     = 2'h0;
  localparam logic [1:0]  CODE1     = 2'h1;
  localparam logic [1:0]  CODE2     = 2'h2;
  localparam logic [1:0]  CODE_RSVD = 2'h3;

  // pins 35..37 give the port on code 0x1 and their debug signal on 0x0
  localparam logic [NPINS-1:0] PORT_ON_CODE1 = 7'h0E;
  // pins with a second peripheral on code 0x2
  localparam logic [NPINS-1:0] HAS_ALT_B     = 7'h71;

  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0]  HRESP_OKAY    = 2'h0;

  typedef enum logic [1:0] {
    ROUTE_PORT,
    ROUTE_ALT_A,
    ROUTE_ALT_B,
    ROUTE_NONE
  } route_t;

endpackage

// *** rtl/pin_func_sel.sv ***
// pin function select for pins 34..37 and 41..43 with an AHB-Lite slave
// assumes pads outside resolve pad_out/pad_oe onto the wire
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module pin_func_sel (
  input  wire logic                                clk,
  input  wire logic                                rst,
  // ahb-lite slave
  input  wire logic                                hsel,
  input  wire logic [31:0]                         haddr,
  input  wire logic [1:0]                          htrans,
  input  wire logic                                hwrite,
  input  wire logic [2:0]                          hsize,
  input  wire logic [31:0]                         hwdata,
  input  wire logic                                hready,
  output var  logic                                hreadyout,
  output var  logic [31:0]                         hrdata,
  output var  logic [1:0]                          hresp,
  // pads
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  pad_in,
  output var  logic [pin_func_sel_pkg::NPINS-1:0]  pad_out,
  output var  logic [pin_func_sel_pkg::NPINS-1:0]  pad_oe,
  // general purpose port logic
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  gpio_out,
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  gpio_oe,
  output var  logic [pin_func_sel_pkg::NPINS-1:0]  gpio_in,
  // first peripheral per pin
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  alt_a_out,
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  alt_a_oe,
  output var  logic [pin_func_sel_pkg::NPINS-1:0]  alt_a_in,
  // second peripheral per pin
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  alt_b_out,
  input  wire logic [pin_func_sel_pkg::NPINS-1:0]  alt_b_oe,
  output var  logic [pin_func_sel_pkg::NPINS-1:0]  alt_b_in
);

  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  logic        wr_pend_q, wr_pend_d;
  logic [1:0]  wr_sel_q,  wr_sel_d;
  logic [7:0]  p3u_q,     p3u_d;
  logic [7:0]  p4l_q,     p4l_d;
  logic [31:0] rdata_q,   rdata_d;
  logic        addr_ok;
  logic [1:0]  hit;
  logic [7:0]  p3u_now;
  logic [7:0]  p4l_now;

  // a write in its data phase lands this cycle; reads see it at once
  always_comb begin
    p3u_now = p3u_q;
    p4l_now = p4l_q;
    if (wr_pend_q && wr_sel_q[0]) begin
      p3u_now = hwdata[7:0];                                   // RQ1
    end
    if (wr_pend_q && wr_sel_q[1]) begin
      p4l_now = hwdata[7:0];                                   // RQ5
    end
  end

  always_comb begin
    addr_ok   = hsel && hready && (htrans == pin_func_sel_pkg::HTRANS_NONSEQ);
    hit[0]    = (haddr == pin_func_sel_pkg::P3U_ADDR);
    hit[1]    = (haddr == pin_func_sel_pkg::P4L_ADDR);
    wr_pend_d = addr_ok && hwrite && (hit != 2'b00);
    wr_sel_d  = wr_pend_d ? hit : 2'b00;
    p3u_d     = p3u_now;                                       // RQ2 RQ3 RQ4
    p4l_d     = p4l_now;                                       // RQ6 RQ7
    rdata_d   = rdata_q;
    if (addr_ok && !hwrite) begin
      // unmapped reads return zero
      if (hit[0]) begin
        rdata_d = {24'h000000, p3u_now};
      end else if (hit[1]) begin
        rdata_d = {24'h000000, p4l_now};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_q <= 1'b0;
      wr_sel_q  <= 2'b00;
      p3u_q     <= pin_func_sel_pkg::SEL_RESET;                // RQ1 RQ2 RQ3
      p4l_q     <= pin_func_sel_pkg::SEL_RESET;                // RQ6 RQ7
      rdata_q   <= 32'h00000000;
    end else begin
      wr_pend_q <= wr_pend_d;
      wr_sel_q  <= wr_sel_d;
      p3u_q     <= p3u_d;
      p4l_q     <= p4l_d;
      rdata_q   <= rdata_d;
    end
  end

  // zero wait states and always okay; kept in flops so outputs are registered
  logic       hready_q;
  logic [1:0] hresp_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hready_q <= 1'b1;
      hresp_q  <= pin_func_sel_pkg::HRESP_OKAY;
    end else begin
      hready_q <= 1'b1;
      hresp_q  <= pin_func_sel_pkg::HRESP_OKAY;
    end
  end

  always_comb begin
    hreadyout = hready_q;
    hrdata    = rdata_q;
    hresp     = hresp_q;
  end

  // ----------------------------------------
  // pad input synchroniser
  // ----------------------------------------
  logic [pin_func_sel_pkg::NPINS-1:0] pin_meta_q;
  logic [pin_func_sel_pkg::NPINS-1:0] pin_sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pad_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------
  // routing
  // ----------------------------------------
  function automatic pin_func_sel_pkg::route_t decode(
    input logic [1:0] code,
    input logic       port_on1,
    input logic       has_b
  );
    pin_func_sel_pkg::route_t r;
    r = pin_func_sel_pkg::ROUTE_NONE;
    case (code)
      pin_func_sel_pkg::CODE0: begin
        r = port_on1 ? pin_func_sel_pkg::ROUTE_ALT_A
                     : pin_func_sel_pkg::ROUTE_PORT;           // RQ3
      end
      pin_func_sel_pkg::CODE1: begin
        r = port_on1 ? pin_func_sel_pkg::ROUTE_PORT
                     : pin_func_sel_pkg::ROUTE_ALT_A;          // RQ4 RQ5 RQ6
      end
      pin_func_sel_pkg::CODE2: begin
        r = has_b ? pin_func_sel_pkg::ROUTE_ALT_B
                  : pin_func_sel_pkg::ROUTE_NONE;              // RQ4 RQ5 RQ6
      end
      default: begin
        r = pin_func_sel_pkg::ROUTE_NONE;                      // RQ2 RQ7
      end
    endcase
    return r;
  endfunction

  logic [15:0] sel_all;
  logic [pin_func_sel_pkg::NPINS-1:0] pad_out_d, pad_oe_d;
  logic [pin_func_sel_pkg::NPINS-1:0] gpio_in_d, alt_a_in_d, alt_b_in_d;
  logic [pin_func_sel_pkg::NPINS-1:0] pad_out_q, pad_oe_q;
  logic [pin_func_sel_pkg::NPINS-1:0] gpio_in_q, alt_a_in_q, alt_b_in_q;

  // routing follows the stored fields, one cycle after the write lands
  always_comb begin
    pin_func_sel_pkg::route_t rt;
    logic [1:0]               code;
    rt         = pin_func_sel_pkg::ROUTE_NONE;
    code       = 2'h0;
    sel_all    = {p4l_q, p3u_q};
    pad_out_d  = '0;
    pad_oe_d   = '0;
    gpio_in_d  = '0;
    alt_a_in_d = '0;
    alt_b_in_d = '0;
    for (int i = 0; i < pin_func_sel_pkg::NPINS; i++) begin
      // port 4 pins skip the pin 40 field in bits 1:0
      code = (i < 4) ? sel_all[2*i +: 2] : sel_all[2*i+2 +: 2];
      rt   = decode(code, pin_func_sel_pkg::PORT_ON_CODE1[i],
                    pin_func_sel_pkg::HAS_ALT_B[i]);
      case (rt)
        pin_func_sel_pkg::ROUTE_PORT: begin
          pad_out_d[i] = gpio_out[i];                          // RQ8
          pad_oe_d[i]  = gpio_oe[i];
          gpio_in_d[i] = pin_sync_q[i];
        end
        pin_func_sel_pkg::ROUTE_ALT_A: begin
          pad_out_d[i]  = alt_a_out[i];                        // RQ8
          pad_oe_d[i]   = alt_a_oe[i];
          alt_a_in_d[i] = pin_sync_q[i];
        end
        pin_func_sel_pkg::ROUTE_ALT_B: begin
          pad_out_d[i]  = alt_b_out[i];                        // RQ8
          pad_oe_d[i]   = alt_b_oe[i];
          alt_b_in_d[i] = pin_sync_q[i];
        end
        default: begin
          // reserved code: pad floats, nobody sees it
          pad_out_d[i] = 1'b0;
          pad_oe_d[i]  = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pad_out_q  <= '0;
      pad_oe_q   <= '0;
      gpio_in_q  <= '0;
      alt_a_in_q <= '0;
      alt_b_in_q <= '0;
    end else begin
      pad_out_q  <= pad_out_d;
      pad_oe_q   <= pad_oe_d;
      gpio_in_q  <= gpio_in_d;
      alt_a_in_q <= alt_a_in_d;
      alt_b_in_q <= alt_b_in_d;
    end
  end

  always_comb begin
    pad_out  = pad_out_q;
    pad_oe   = pad_oe_q;
    gpio_in  = gpio_in_q;
    alt_a_in = alt_a_in_q;
    alt_b_in = alt_b_in_q;
  end

endmodule // pin_func_sel

`default_nettype wire

// *** verif/pad_model.sv ***
// far side of the seven pins: pad wire seen by the block
// ext is the outside driver; the bench changes it between checks
`timescale 1ns/1ps
`default_nettype none

module pad_model (
  input  wire logic [6:0] pad_out,
  input  wire logic [6:0] pad_oe,
  input  wire logic [6:0] ext,
  output var  logic [6:0] pad_in
);
  // released pins show the outside level, never a stale block value
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext);
endmodule  // pad_model
`default_nettype wire

// *** verif/pin_func_sel_monitor.sv ***
// checker for pin_func_sel: bus answers and pin routing
// sees only top ports; one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none

module pin_func_sel_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic [1:0]  hresp,
  input wire logic [6:0]  pad_in,
  input wire logic [6:0]  pad_out,
  input wire logic [6:0]  pad_oe,
  input wire logic [6:0]  gpio_out,
  input wire logic [6:0]  gpio_oe,
  input wire logic [6:0]  gpio_in,
  input wire logic [6:0]  alt_a_out,
  input wire logic [6:0]  alt_a_oe,
  input wire logic [6:0]  alt_a_in,
  input wire logic [6:0]  alt_b_out,
  input wire logic [6:0]  alt_b_oe,
  input wire logic [6:0]  alt_b_in
);
  // ----------------------------------------
  // shadow of the select registers
  // ----------------------------------------
  localparam logic [31:0] A3 = pin_func_sel_pkg::P3U_ADDR;
  localparam logic [31:0] A4 = pin_func_sel_pkg::P4L_ADDR;
  logic [7:0]  p3_q, p3_d, p4_q, p4_d, rv;
  logic        wr_q, wr_d;
  logic [31:0] ad_q;
  logic [1:0]  up_q, up_d;
  logic [13:0] cd;
  logic [6:0]  rp, ra, rb, eo, eu;

  // {second, first, port}; code 3 routes nowhere
  function automatic logic [2:0] rt(input int i, input logic [1:0] c);
    if (i inside {[1:3]})
      return {1'b0, c == 2'h0, c == 2'h1};
    return {c == 2'h2, c == 2'h1, c == 2'h0};
  endfunction

  always_comb begin
    wr_d = hsel && hready && htrans == 2'h2 && hwrite;
    p3_d = p3_q;
    p4_d = p4_q;
    if (wr_q && ad_q == A3) p3_d = hwdata[7:0];
    if (wr_q && ad_q == A4) p4_d = hwdata[7:0];
    up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {p3_q, p4_q, wr_q, ad_q, up_q} <= '0;
    end else begin
      {p3_q, p4_q, wr_q, ad_q, up_q} <= {p3_d, p4_d, wr_d, haddr, up_d};
    end
  end

  always_comb begin
    cd = {p4_q[7:2], p3_q};
    rv = (ad_q == A3) ? p3_q : (ad_q == A4) ? p4_q : 8'h00;
    for (int i = 0; i < 7; i++) begin
      {rb[i], ra[i], rp[i]} = rt(i, cd[2*i +: 2]);
    end
  end
  assign eo = (rp & gpio_oe) | (ra & alt_a_oe) | (rb & alt_b_oe);
  assign eu = (rp & gpio_out) | (ra & alt_a_out) | (rb & alt_b_out);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_take;
    hsel && hready && htrans == 2'h2 && !hwrite;
  endsequence
  sequence s_data_phase;
    s_rd_take ##1 1'b1;
  endsequence

  a_bus_okay: assert property (hreadyout && hresp == 2'h0)
    else $error("bus answer not ready or not okay");
  a_read_back: assert property (
    s_data_phase |-> hrdata == {24'h0, rv})
    else $error("read data differs from stored select");
  a_oe_route: assert property (
    up_q != 2'h0 |-> pad_oe == $past(eo))
    else $error("pad enable not from selected source");
  a_out_route: assert property (
    up_q != 2'h0 |-> pad_out == $past(eu))
    else $error("pad level not from selected source");
  a_port_in: assert property (
    up_q == 2'h3 |-> gpio_in == ($past(rp) & $past(pad_in, 3)))
    else $error("port input not routed");
  a_first_in: assert property (
    up_q == 2'h3 |-> alt_a_in == ($past(ra) & $past(pad_in, 3)))
    else $error("first peripheral input not routed");
  a_second_in: assert property (
    up_q == 2'h3 |-> alt_b_in == ($past(rb) & $past(pad_in, 3)))
    else $error("second peripheral input not routed");
  a_rsvd_float: assert property (
    up_q != 2'h0 && $past(cd[5:4]) == 2'h3 && $past(cd[9:8]) == 2'h3
    |-> pad_oe[2] == 1'b0 && pad_oe[4] == 1'b0)
    else $error("reserved code drives the pad");
endmodule  // pin_func_sel_monitor

bind pin_func_sel pin_func_sel_monitor chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
  .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
  .alt_a_out(alt_a_out), .alt_a_oe(alt_a_oe), .alt_a_in(alt_a_in),
  .alt_b_out(alt_b_out), .alt_b_oe(alt_b_oe), .alt_b_in(alt_b_in));
`default_nettype wire

// *** verif/tb_top.sv ***
// bench for pin_func_sel: registers over ahb-lite, random pin traffic
// pad_model stands in for the far side of every pin
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  localparam logic [31:0] A3 = pin_func_sel_pkg::P3U_ADDR;
  localparam logic [31:0] A4 = pin_func_sel_pkg::P4L_ADDR;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hwrite = 1'b0;
  logic        hsel = 1'b1;
  logic        hrdy;
  logic [1:0]  htrans = 2'h0;
  logic [1:0]  hresp;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [6:0]  go = '0, ge = '0, ao = '0, ae = '0, bo = '0, be = '0;
  logic [6:0]  ext = '0, pin, pout, poe, gi, ai, bi;
  int          failures = 0;
  int          num_checks = 0;

  always #4 clk = ~clk;

  pin_func_sel uut (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .pad_in(pin),
    .pad_out(pout), .pad_oe(poe), .gpio_out(go), .gpio_oe(ge),
    .gpio_in(gi), .alt_a_out(ao), .alt_a_oe(ae), .alt_a_in(ai),
    .alt_b_out(bo), .alt_b_oe(be), .alt_b_in(bi));
  pad_model pads (.pad_out(pout), .pad_oe(poe), .ext(ext), .pad_in(pin));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] r);
    // no local limit: only the watchdog ends a wait
    {htrans, haddr, hwrite} <= {2'h2, a, w};
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask

  // upper data bits set on purpose: only the low byte is stored
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, a, {24'hFFFFFF, d}, r);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    cmp("read data", {24'h0, e}, r);
  endtask

  // {pad_out, pad_oe, port in, first in, second in} for pin i
  function automatic logic [4:0] exp_pin(int i, logic [13:0] cd);
    logic [1:0] c, r;
    logic [3:0] ov, ev;
    logic       pd;
    c = cd[2*i +: 2];
    r = (i inside {[1:3]}) ? (c == 2'h0 ? 2'h1 : c == 2'h1 ? 2'h0 : 2'h3)
                           : c;
    ov = {1'b0, bo[i], ao[i], go[i]};
    ev = {1'b0, be[i], ae[i], ge[i]};
    pd = ev[r] ? ov[r] : ext[i];
    return {ov[r], ev[r], pd & (r == 2'h0), pd & (r == 2'h1),
            pd & (r == 2'h2)};
  endfunction

  task automatic route_chk(input logic [7:0] r3, input logic [7:0] r4);
    logic [63:0] v;
    v = {$urandom, $urandom};
    {go, ge, ao, ae, bo, be, ext} <= v[48:0];
    repeat (5) @(posedge clk);
    #1;
    for (int i = 0; i < 7; i++)
      cmp("pin route", 32'(exp_pin(i, {r4[7:2], r3})),
          32'({pout[i], poe[i], gi[i], ai[i], bi[i]}));
    // hand back on an edge so the next request starts there
    @(posedge clk);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    logic [7:0]  a, b;
    void'($urandom(50));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(A3, 8'h00);
    rd(A4, 8'h00);
    route_chk(8'h00, 8'h00);
    $display("test reset done");
    for (int n = 0; n < 24; n++) begin
      a = (n < 4) ? {4{n[1:0]}} : 8'($urandom);
      b = (n < 4) ? {4{n[1:0]}} : 8'($urandom);
      wr(A3, a);
      wr(A4, b);
      rd(A3, a);
      rd(A4, b);
      route_chk(a, b);
    end
    $display("test codes done");
    wr(A4 + 32'h4, 8'hFF);
    rd(A4 + 32'h4, 8'h00);
    rd(A4, b);
    // a write while the slave is not selected must be ignored
    hsel <= 1'b0;
    wr(A3, ~a);
    hsel <= 1'b1;
    rd(A3, a);
    $display("test unmapped done");
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(A3, 8'h00);
    route_chk(8'h00, 8'h00);
    $display("test rereset done");
    finish_test;
  end

  initial begin
    #20000;
    failures++;
    finish_test;
  end
endmodule  // tb_top
`default_nettype wire
